// >>> shared/led_train_pkg.sv
// constants shared by the led pulse train generator files
package led_train_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam longint CLK_PERIOD_NS = 64'd20;
    localparam longint DUR0_NS       = 64'd41670000;
    localparam longint DUR1_NS       = 64'd55550000;
    localparam longint DUR2_NS       = 64'd83330000;
    localparam longint DUR3_NS       = 64'd125000000;
    localparam int     CNT_W         = 23;
    localparam logic [CNT_W-1:0] DUR0_CYC = CNT_W'(DUR0_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] DUR1_CYC = CNT_W'(DUR1_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] DUR2_CYC = CNT_W'(DUR2_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] DUR3_CYC = CNT_W'(DUR3_NS / CLK_PERIOD_NS);

    // ----------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [29:0] IDX_TRAIN3_PATTERN_LOW = 30'h76;
    localparam logic [29:0] IDX_TRAIN3_TIMING_HIGH = 30'h77;
    localparam logic [29:0] IDX_TRAIN4_PATTERN_LOW = 30'h78;
    localparam logic [29:0] IDX_TRAIN4_TIMING_HIGH = 30'h79;
    localparam logic [29:0] IDX_TRAIN5_PATTERN_LOW = 30'h7a;
    localparam logic [29:0] IDX_TRAIN5_TIMING_HIGH = 30'h7b;
    localparam logic [29:0] IDX_TRAIN_STATUS       = 30'h80;
    localparam int          NUM_CH                 = 3;
    localparam int          NUM_CFG                = 6;
    localparam logic [2:0]  SEL_STATUS             = 3'h6;
    localparam logic [2:0]  SEL_NONE               = 3'h7;
    localparam logic [7:0]  CFG_RESET              = 8'h00;

    // ----------------------------------------------------------------
    // fields of the timing_high register
    // ----------------------------------------------------------------
    localparam int DUR_MSB = 7;
    localparam int DUR_LSB = 6;
    localparam int LEN_MSB = 5;
    localparam int LEN_LSB = 4;
    localparam int PHI_MSB = 3;
    localparam int PHI_LSB = 0;

    // last position index for each length code
    localparam logic [3:0] LAST_LEN12 = 4'hb;
    localparam logic [3:0] LAST_LEN10 = 4'h9;
    localparam logic [3:0] LAST_LEN9  = 4'h8;
    localparam logic [3:0] LAST_LEN8  = 4'h7;

    // status word layout
    localparam int STAT_POS_W   = 4;
    localparam int STAT_LED_LSB = 12;

endpackage : led_train_pkg

// >>> verilog/led_train_channel.sv
// one led pulse train channel: interval counter, position counter, led drive
`timescale 1ns/100ps
module led_train_channel #(
    parameter logic [22:0] DUR0_CYC = led_train_pkg::DUR0_CYC,
    parameter logic [22:0] DUR1_CYC = led_train_pkg::DUR1_CYC,
    parameter logic [22:0] DUR2_CYC = led_train_pkg::DUR2_CYC,
    parameter logic [22:0] DUR3_CYC = led_train_pkg::DUR3_CYC
) (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_i,
    input  wire logic [7:0] pattern_low_i,
    input  wire logic [7:0] timing_high_i,
    output logic            led_o,
    output logic [3:0]      position_o
);

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    function automatic logic [3:0] last_position(input logic [1:0] len);
        case (len)
            2'h0:    last_position = led_train_pkg::LAST_LEN12;
            2'h1:    last_position = led_train_pkg::LAST_LEN10;
            2'h2:    last_position = led_train_pkg::LAST_LEN9;
            default: last_position = led_train_pkg::LAST_LEN8;
        endcase
    endfunction : last_position

    logic [11:0] pattern_w;
    logic [1:0]  bit_duration_select;
    logic [1:0]  sequence_length_select;
    logic [22:0] dur_cnt;
    logic [3:0]  last_w;
    logic        tick;
    logic [22:0] cnt_reg;
    logic [3:0]  pos_reg;
    logic [3:0]  pos_next;
    logic        led_reg;

    assign pattern_w = {timing_high_i[led_train_pkg::PHI_MSB:led_train_pkg::PHI_LSB],
                        pattern_low_i};
    assign bit_duration_select    = timing_high_i[led_train_pkg::DUR_MSB:led_train_pkg::DUR_LSB];
    assign sequence_length_select = timing_high_i[led_train_pkg::LEN_MSB:led_train_pkg::LEN_LSB];
    assign last_w                 = last_position(sequence_length_select);

    always_comb begin
        case (bit_duration_select)
            2'h0:    dur_cnt = DUR0_CYC;
            2'h1:    dur_cnt = DUR1_CYC;
            2'h2:    dur_cnt = DUR2_CYC;
            default: dur_cnt = DUR3_CYC;
        endcase
    end

    // ----------------------------------------------------------------
    // counters
    // ----------------------------------------------------------------
    // a shortened duration written mid-interval ends the interval at once
    assign tick = (cnt_reg >= dur_cnt - 23'h000001);

    always_comb begin
        if (!tick) begin
            pos_next = pos_reg;
        end else if (pos_reg >= last_w) begin
            pos_next = 4'h0;
        end else begin
            pos_next = pos_reg + 4'h1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            cnt_reg <= 23'h000000;
        end else if (ce_i) begin
            cnt_reg <= tick ? 23'h000000 : cnt_reg + 23'h000001;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            pos_reg <= 4'h0;
        end else if (ce_i) begin
            pos_reg <= pos_next;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            led_reg <= 1'b0;
        end else if (ce_i) begin
            led_reg <= pattern_w[pos_next];
        end
    end

    assign led_o      = led_reg;
    assign position_o = pos_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence seq_at_last;
        ce_i && tick && (pos_reg >= last_w);
    endsequence

    sequence seq_at_zero;
        pos_reg == 4'h0;
    endsequence

    AST_WRAP_TO_ZERO: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        seq_at_last |=> seq_at_zero) else $error("position did not wrap to zero");

    AST_LEN8_WRAP: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (ce_i && tick && sequence_length_select == 2'h3 && pos_reg == 4'h7) |=> pos_reg == 4'h0)
        else $error("length eight did not wrap after position seven");

    AST_ADVANCE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (ce_i && tick && pos_reg < last_w) |=> pos_reg == $past(pos_reg) + 4'h1)
        else $error("position did not advance by one");

    AST_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (!ce_i || !tick) |=> $stable(pos_reg)) else $error("position moved early");

    AST_DURATION: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ($changed(pos_reg) && $past(rst_n_i)) |-> ($past(cnt_reg) + 23'h000001 >= $past(dur_cnt)))
        else $error("position interval shorter than selected duration");

    AST_LED_MATCH: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ce_i |=> (led_reg == pattern_w[pos_reg]) || $changed(pattern_w))
        else $error("led does not match pattern bit");

    AST_RESET_STATE: assert property (@(posedge ref_clk_i)
        !rst_n_i |=> (pos_reg == 4'h0 && !led_reg && cnt_reg == 23'h000000))
        else $error("channel not cleared by reset");

endmodule : led_train_channel

// >>> verilog/led_train_top.sv
// led pulse train generators for channels three to five behind an ahb-lite slave
`timescale 1ns/100ps
module led_train_top #(
    parameter logic [22:0] DUR0_CYC = led_train_pkg::DUR0_CYC,
    parameter logic [22:0] DUR1_CYC = led_train_pkg::DUR1_CYC,
    parameter logic [22:0] DUR2_CYC = led_train_pkg::DUR2_CYC,
    parameter logic [22:0] DUR3_CYC = led_train_pkg::DUR3_CYC
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic [31:0]      hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic [2:0]       led_o
);

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    // configuration selects 0..5 follow the register indices in order:
    // even = pattern_low, odd = timing_high, channel = select / 2
    function automatic logic [2:0] reg_select(input logic [31:0] addr);
        logic [29:0] idx;
        idx = addr[31:2];
        if (idx == led_train_pkg::IDX_TRAIN_STATUS) begin
            reg_select = led_train_pkg::SEL_STATUS;
        end else if (idx >= led_train_pkg::IDX_TRAIN3_PATTERN_LOW &&
                     idx <= led_train_pkg::IDX_TRAIN5_TIMING_HIGH) begin
            reg_select = 3'(idx - led_train_pkg::IDX_TRAIN3_PATTERN_LOW);
        end else begin
            reg_select = led_train_pkg::SEL_NONE;
        end
    endfunction : reg_select

    logic        addr_ok;
    logic [2:0]  addr_sel;
    logic        wr_pend_reg;
    logic [2:0]  wr_sel_reg;
    logic [7:0]  cfg_reg [led_train_pkg::NUM_CFG];
    logic [31:0] hrdata_reg;
    logic        hreadyout_reg;
    logic        hresp_reg;
    logic [31:0] status_w;
    logic [31:0] rd_word;
    logic [3:0]  pos_w [led_train_pkg::NUM_CH];
    logic [2:0]  led_w;

    // only whole-word transfers are expected; narrower ones act as full words
    assign addr_ok  = hsel_i && htrans_i[1] && hready_i;
    assign addr_sel = reg_select(haddr_i);

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    // zero wait states, always okay; the bus keeps working while ce_i is low
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            hreadyout_reg <= 1'b1;
            hresp_reg     <= 1'b0;
        end else begin
            hreadyout_reg <= 1'b1;
            hresp_reg     <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            wr_pend_reg <= 1'b0;
            wr_sel_reg  <= led_train_pkg::SEL_NONE;
        end else begin
            wr_pend_reg <= addr_ok && hwrite_i && (addr_sel < led_train_pkg::SEL_STATUS);
            wr_sel_reg  <= addr_sel;
        end
    end

    generate
        for (genvar r = 0; r < led_train_pkg::NUM_CFG; r++) begin : g_cfg
            always_ff @(posedge ref_clk_i) begin
                if (!rst_n_i) begin
                    cfg_reg[r] <= led_train_pkg::CFG_RESET;
                end else if (wr_pend_reg && wr_sel_reg == 3'(r)) begin
                    cfg_reg[r] <= hwdata_i[7:0];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // status: four position bits per channel, then the three led levels
    always_comb begin
        status_w = 32'h00000000;
        for (int c = 0; c < led_train_pkg::NUM_CH; c++) begin
            status_w[c*led_train_pkg::STAT_POS_W +: led_train_pkg::STAT_POS_W] = pos_w[c];
        end
        status_w[led_train_pkg::STAT_LED_LSB +: led_train_pkg::NUM_CH] = led_w;
    end

    // a read right behind a write to the same register sees the new byte
    always_comb begin
        rd_word = 32'h00000000;
        if (addr_sel == led_train_pkg::SEL_STATUS) begin
            rd_word = status_w;
        end else if (addr_sel < led_train_pkg::SEL_STATUS) begin
            if (wr_pend_reg && wr_sel_reg == addr_sel) begin
                rd_word[7:0] = hwdata_i[7:0];
            end else begin
                rd_word[7:0] = cfg_reg[addr_sel];
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            hrdata_reg <= 32'h00000000;
        end else if (addr_ok && !hwrite_i) begin
            hrdata_reg <= rd_word;
        end
    end

    assign hrdata_o    = hrdata_reg;
    assign hreadyout_o = hreadyout_reg;
    assign hresp_o     = hresp_reg;

    // ----------------------------------------------------------------
    // generators
    // ----------------------------------------------------------------
    // independent channels
    generate
        for (genvar c = 0; c < led_train_pkg::NUM_CH; c++) begin : g_ch
            led_train_channel #(
                .DUR0_CYC (DUR0_CYC),
                .DUR1_CYC (DUR1_CYC),
                .DUR2_CYC (DUR2_CYC),
                .DUR3_CYC (DUR3_CYC)
            ) u_channel (
                .ref_clk_i     (ref_clk_i),
                .rst_n_i       (rst_n_i),
                .ce_i          (ce_i),
                .pattern_low_i (cfg_reg[2*c]),
                .timing_high_i (cfg_reg[2*c+1]),
                .led_o         (led_w[c]),
                .position_o    (pos_w[c])
            );
        end
    endgenerate

    assign led_o = led_w;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    AST_WRITE_STORES: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        wr_pend_reg |=> cfg_reg[$past(wr_sel_reg)] == $past(hwdata_i[7:0]))
        else $error("written byte not stored");

    AST_READ_BACK: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (addr_ok && !hwrite_i && addr_sel < led_train_pkg::SEL_STATUS && !wr_pend_reg)
        |=> (hrdata_o[7:0] == cfg_reg[$past(addr_sel)] && hrdata_o[31:8] == 24'h000000))
        else $error("register read back wrong");

    AST_NO_WAIT: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        hreadyout_o && !hresp_o) else $error("slave stalled or errored");

    AST_STATUS_POS: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (addr_ok && !hwrite_i && addr_sel == led_train_pkg::SEL_STATUS)
        |=> hrdata_o[3:0] == $past(pos_w[0])) else $error("status position wrong");

    // ----------------------------------------------------------------
    // status, read path, write path and reset assertions
    // ----------------------------------------------------------------
    AST_STATUS_POS4: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (addr_ok && !hwrite_i && addr_sel == led_train_pkg::SEL_STATUS)
        |=> hrdata_o[7:4] == $past(pos_w[1])) else $error("status position four wrong");

    AST_STATUS_POS5: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (addr_ok && !hwrite_i && addr_sel == led_train_pkg::SEL_STATUS)
        |=> hrdata_o[11:8] == $past(pos_w[2])) else $error("status position five wrong");

    AST_STATUS_LED: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (addr_ok && !hwrite_i && addr_sel == led_train_pkg::SEL_STATUS)
        |=> hrdata_o[14:12] == $past(led_w)) else $error("status led levels wrong");

    AST_STATUS_ZERO: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (addr_ok && !hwrite_i && addr_sel == led_train_pkg::SEL_STATUS)
        |=> hrdata_o[31:15] == 17'h00000) else $error("status spare bits not zero");

    AST_UNMAPPED_ZERO: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (addr_ok && !hwrite_i && addr_sel == led_train_pkg::SEL_NONE)
        |=> hrdata_o == 32'h00000000) else $error("unmapped read not zero");

    AST_UPPER_ZERO: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (addr_ok && !hwrite_i && addr_sel < led_train_pkg::SEL_STATUS)
        |=> hrdata_o[31:8] == 24'h000000) else $error("register upper bits not zero");

    AST_WRITE_TAKEN: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (addr_ok && hwrite_i && addr_sel < led_train_pkg::SEL_STATUS)
        |=> (wr_pend_reg && wr_sel_reg == $past(addr_sel))) else $error("write not taken");

    AST_IGNORED_WRITE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (addr_ok && hwrite_i && addr_sel >= led_train_pkg::SEL_STATUS)
        |=> !wr_pend_reg) else $error("write to read-only place taken");

    AST_HRDATA_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !(addr_ok && !hwrite_i) |=> $stable(hrdata_o))
        else $error("read data changed without a read");

    AST_LED_RESET: assert property (@(posedge ref_clk_i)
        !rst_n_i |=> led_o == 3'h0) else $error("leds not off after reset");

    AST_CFG_RESET: assert property (@(posedge ref_clk_i)
        !rst_n_i |=> (cfg_reg[0] == led_train_pkg::CFG_RESET
            && cfg_reg[1] == led_train_pkg::CFG_RESET && cfg_reg[2] == led_train_pkg::CFG_RESET
            && cfg_reg[3] == led_train_pkg::CFG_RESET && cfg_reg[4] == led_train_pkg::CFG_RESET
            && cfg_reg[5] == led_train_pkg::CFG_RESET)) else $error("settings not cleared");

endmodule : led_train_top

// >>> test/led_train_top_tb.sv
// self-checking bench for the led pulse train generator block
`timescale 1ns/100ps
module led_train_top_tb;
    // ----------------------------------------------------------------
    // shortened durations keep the run short
    // ----------------------------------------------------------------
    localparam logic [22:0] DC [4] = '{23'h4, 23'h5, 23'h6, 23'h8};
    localparam int          LENS [4] = '{12, 10, 9, 8};
    localparam logic [29:0] BASE = led_train_pkg::IDX_TRAIN3_PATTERN_LOW;
    logic        ref_clk_i;
    logic        rst_n_i;
    logic        ce_i;
    logic        hsel_i;
    logic [31:0] haddr_i;
    logic [1:0]  htrans_i;
    logic        hwrite_i;
    logic [2:0]  hsize_i;
    logic [31:0] hwdata_i;
    logic        hready_i;
    logic [31:0] hrdata_o;
    logic        hreadyout_o;
    logic        hresp_o;
    logic [2:0]  led_o;
    int          n_errors;
    int          comparisons;
    int          n;
    logic [31:0] s;
    logic [31:0] s2;
    logic [2:0]  l0;
    logic [11:0] pat;
    logic [3:0]  pp;
    logic [3:0]  nx;

    led_train_top #(.DUR0_CYC(DC[0]), .DUR1_CYC(DC[1]), .DUR2_CYC(DC[2]), .DUR3_CYC(DC[3])) dut (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
        .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .led_o(led_o));

    assign hready_i = hreadyout_o;
    always #10 ref_clk_i = ~ref_clk_i;

    // ----------------------------------------------------------------
    // reporting
    // ----------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // ----------------------------------------------------------------
    // ahb-lite single word transfer, entered just after a rising edge
    // ----------------------------------------------------------------
    task automatic bus(input logic [29:0] idx, input logic wr, input logic [31:0] wd,
                       output logic [31:0] rd);
        int k;
        hsel_i   <= 1'b1;
        haddr_i  <= {idx, 2'b00};
        htrans_i <= 2'b10;
        hwrite_i <= wr;
        for (k = 0; k < 50; k++) begin
            @(posedge ref_clk_i);
            if (hready_i === 1'b1) break;
        end
        if (k == 50) begin
            n_errors++;
            tally_and_finish();
        end
        htrans_i <= 2'b00;
        hsel_i   <= 1'b0;
        hwdata_i <= wd;
        for (k = 0; k < 50; k++) begin
            @(posedge ref_clk_i);
            if (hready_i === 1'b1) break;
        end
        rd = hrdata_o;
        chk("hresp", 32'h0, {31'h0, hresp_o});
        if (k == 50) begin
            n_errors++;
            tally_and_finish();
        end
    endtask : bus

    task automatic wreg(input logic [29:0] idx, input logic [31:0] d);
        logic [31:0] dummy;
        bus(idx, 1'b1, d, dummy);
    endtask : wreg

    task automatic rreg(input logic [29:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        bus(idx, 1'b0, 32'h0, d);
        chk("register", exp, d);
    endtask : rreg

    // cycles until the next change (or rising edge) of one led
    task automatic gap(input int ch, input bit rise, output int cnt);
        logic prev;
        int   k;
        prev = led_o[ch];
        cnt  = 0;
        for (k = 0; k < 400; k++) begin
            @(posedge ref_clk_i);
            cnt++;
            if (led_o[ch] !== prev && (!rise || led_o[ch] === 1'b1)) break;
            prev = led_o[ch];
        end
        if (k == 400) begin
            n_errors++;
            tally_and_finish();
        end
    endtask : gap

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        ref_clk_i = 1'b0;
        rst_n_i = 1'b0;
        ce_i = 1'b1;
        hsel_i = 1'b0;
        haddr_i = 32'h0;
        htrans_i = 2'b00;
        hwrite_i = 1'b0;
        hsize_i = 3'h2;
        hwdata_i = 32'h0;
        n_errors = 0;
        comparisons = 0;
        repeat (5) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        @(posedge ref_clk_i);
        for (int i = 0; i < 6; i++) rreg(BASE + 30'(i), 32'h0);
        chk("led_o", 32'h0, {29'h0, led_o});
        for (int i = 0; i < 6; i++) wreg(BASE + 30'(i), 32'hffff_ff00 | 32'(8'h5a ^ 8'(i)));
        for (int i = 0; i < 6; i++) rreg(BASE + 30'(i), 32'(8'h5a ^ 8'(i)));
        // unmapped place keeps reading zero
        wreg(30'h7c, 32'h0000_00ff);
        rreg(30'h7c, 32'h0);
        // alternating pattern: led toggles once per position
        wreg(BASE, 32'h55);
        for (int d = 0; d < 4; d++) begin
            wreg(BASE + 30'h1, {24'h0, 2'(d), 2'b00, 4'h5});
            // the led lags a settings write by one cycle; skip that glitch
            repeat (2) @(posedge ref_clk_i);
            gap(0, 1'b0, n);
            gap(0, 1'b0, n);
            chk("duration", 32'(DC[d]), n);
        end
        // single lit position: one flash per full train, on every channel
        for (int l = 0; l < 4; l++) begin
            wreg(BASE + 30'(2 * (l % 3)), 32'h01);
            wreg(BASE + 30'(2 * (l % 3) + 1), {24'h0, 2'b00, 2'(l), 4'h0});
            repeat (2) @(posedge ref_clk_i);
            gap(l % 3, 1'b1, n);
            gap(l % 3, 1'b1, n);
            chk("train period", 32'(LENS[l]) * 32'(DC[0]), n);
        end
        // mixed pattern: each position shows its own bit
        pat = 12'h9c5;
        wreg(BASE + 30'h2, {24'h0, pat[7:0]});
        wreg(BASE + 30'h3, {24'h0, 4'hc, pat[11:8]});
        repeat (2) @(posedge ref_clk_i);
        for (int r = 0; r < 60; r++) begin
            bus(led_train_pkg::IDX_TRAIN_STATUS, 1'b0, 32'h0, s);
            chk("position range", 32'h1, {31'h0, s[7:4] <= 4'hb});
            chk("led level", {31'h0, pat[s[7:4]]}, {31'h0, s[13]});
            nx = (pp == 4'hb) ? 4'h0 : pp + 4'h1;
            if (r > 0) begin
                chk("step", 32'h1, {31'h0, s[7:4] == pp || s[7:4] == nx});
            end
            pp = s[7:4];
        end
        // clock enable low freezes every generator
        ce_i <= 1'b0;
        @(posedge ref_clk_i);
        @(posedge ref_clk_i);
        l0 = led_o;
        bus(led_train_pkg::IDX_TRAIN_STATUS, 1'b0, 32'h0, s);
        repeat (30) @(posedge ref_clk_i);
        bus(led_train_pkg::IDX_TRAIN_STATUS, 1'b0, 32'h0, s2);
        chk("frozen status", s, s2);
        chk("frozen led", {29'h0, l0}, {29'h0, led_o});
        ce_i <= 1'b1;
        // reset in mid-run clears settings and leds
        rst_n_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        @(posedge ref_clk_i);
        for (int i = 0; i < 6; i++) rreg(BASE + 30'(i), 32'h0);
        chk("led_o", 32'h0, {29'h0, led_o});
        tally_and_finish();
    end
endmodule : led_train_top_tb
